// file: design/floppy_drive_pin_control.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "fdd_pin_consts.svh"

// Overview of operation
// R1 - during a seek, direction is active for step in, inactive for step out
// R2 - direction stays inactive while a read or write is running
// R3 - two active-low drive selects decoded from the low drive-number bits
// R4 - each drive select is gated by its motor enable bit
// R5 - four-drive enable makes the selects an encoded drive number
// R6 - swap bit exchanges logical drives of the two selects
// R7 - extra shared select carries select 1, or select 0 when swapped, active low
// R8 - printer-port mode without external controller mirrors direction, side, door change
// R9 - rate outputs follow the last written rate field of either rate register
// R10 - dma request active high, gated by dma enable in at and model 30 modes
// R11 - second mode: dma request always enabled, enable bit reads reserved
// R12 - second mode reports second-drive-present level in status a
// R13 - door change level readable in the digital input register
// R14 - mode bit reuses door change as read gate diagnostic input
// R15 - side select active for side 1, inactive for side 0
// R16 - host holds dma acknowledge high during programmed accesses; the test host keeps it low through them while a request is pending
// R17 - selects, direction and side stay inactive until digital output is written
module floppy_drive_pin_control
    import fdd_pin_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              seek_active,
    input  wire logic              seek_inward,
    input  wire logic              rw_active,
    input  wire logic              side_req,
    input  wire logic              fdc_dma_req,
    input  wire logic              door_change,
    input  wire logic              ppm_door_change,
    input  wire logic              second_drive_present,
    input  wire logic              dma_acknowledge_n,
    output logic                   dir_out,
    output logic                   side_select,
    output logic                   drive_select_a_n,
    output logic                   drive_select_b_n,
    output logic                   rate_out_lo,
    output logic                   rate_out_hi,
    output logic                   dma_request,
    output logic                   dma_transfer,
    output logic                   read_gate_diag,
    output logic                   ppm_pins_oe,
    output logic                   ppm_dir,
    output logic                   ppm_side_select,
    output logic                   ppm_drive_select_n
);

    import fdd_pin_pkg::*;

    generate
        if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
            $error("floppy_drive_pin_control needs ADDR_W between 6 and 32");
        end
    endgenerate

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ADDR_W'(ofs));
    endfunction

    logic [7:0]   digital_output_reg;
    logic [7:0]   function_enable_reg;
    logic [7:0]   function_control_reg;
    logic [7:0]   mode_ctrl_reg;
    rate_t        rate_reg;
    logic         dor_written_reg;
    logic [31:0]  prdata_reg;
    logic [3:0]   pins_sync;
    logic         door_sync;
    logic         ppm_door_sync;
    logic         drive2_sync;
    logic         ack_n_sync;
    compat_mode_t compat_mode;
    logic         second_mode;
    logic         ppm_active;
    logic         dma_enable;
    logic         mapped;
    logic         wr_en;
    logic         rd_setup;
    logic         door_level;
    logic         dir_next;
    logic         sel_a_n;
    logic         sel_b_n;
    logic         sel_ppm_n;
    logic [7:0]   rd_byte;
    logic [7:0]   dig_in_byte;
    logic [7:0]   status_a_byte;
    logic [7:0]   dig_out_byte;

    sync_bits #(
        .WIDTH (4)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({~dma_acknowledge_n, second_drive_present, ppm_door_change, door_change}),
        .sync_out (pins_sync)
    );

    assign door_sync     = pins_sync[0];
    assign ppm_door_sync = pins_sync[1];
    assign drive2_sync   = pins_sync[2];
    // inverted through the synchroniser so its cleared stages read as idle, not as an ack
    assign ack_n_sync    = ~pins_sync[3];

    drive_select_decode u_decode (
        .drive_num  (digital_output_reg[`DOUT_DRV_MSB:`DOUT_DRV_LSB]),
        .motor_on   (digital_output_reg[`DOUT_MOTOR_MSB:`DOUT_MOTOR_LSB]),
        .four_drive (function_enable_reg[`FEN_FOUR_DRIVE]),
        .swap       (function_control_reg[`FCTL_SWAP]),
        .sel_a_n    (sel_a_n),
        .sel_b_n    (sel_b_n),
        .sel_ppm_n  (sel_ppm_n)
    );

    // the illegal mode code behaves as the at mode
    assign compat_mode = compat_mode_t'(mode_ctrl_reg[`MODE_COMPAT_MSB:`MODE_COMPAT_LSB]);
    assign second_mode = (compat_mode == second_compat_mode);
    assign ppm_active  = mode_ctrl_reg[`MODE_PPM] & ~mode_ctrl_reg[`MODE_EXT_CTRL];
    assign dma_enable  = second_mode | digital_output_reg[`DOUT_DMA_EN]; // [R10] [R11]
    // while shared pins carry the floppy signals, door change comes from them
    assign door_level  = ppm_active ? ppm_door_sync : door_sync; // [R8]
    assign dir_next    = dor_written_reg & seek_active & ~rw_active & seek_inward; // [R1] [R2]

    // apb: zero wait states, answer in the first access cycle
    assign pready   = 1'b1;
    assign mapped   = addr_hit(paddr, `OFS_DIG_OUT) | addr_hit(paddr, `OFS_FUNC_EN)
                    | addr_hit(paddr, `OFS_FUNC_CTRL) | addr_hit(paddr, `OFS_CFG_CTRL)
                    | addr_hit(paddr, `OFS_RATE_SEL) | addr_hit(paddr, `OFS_DIG_IN)
                    | addr_hit(paddr, `OFS_STATUS_A) | addr_hit(paddr, `OFS_MODE_CTRL);
    assign pslverr  = psel & penable & ~mapped;
    assign wr_en    = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata   = prdata_reg;

    always_comb begin
        dig_in_byte                = 8'h00;
        dig_in_byte[`DIN_DOOR]     = door_level; // [R13]
        status_a_byte              = 8'h00;
        status_a_byte[`SRA_DRIVE2] = second_mode & drive2_sync; // [R12]
        dig_out_byte               = digital_output_reg;
        // the dma enable position is reserved in the second mode
        dig_out_byte[`DOUT_DMA_EN] = digital_output_reg[`DOUT_DMA_EN] & ~second_mode; // [R11]
        if (addr_hit(paddr, `OFS_DIG_OUT)) begin
            rd_byte = dig_out_byte;
        end else if (addr_hit(paddr, `OFS_FUNC_EN)) begin
            rd_byte = function_enable_reg;
        end else if (addr_hit(paddr, `OFS_FUNC_CTRL)) begin
            rd_byte = function_control_reg;
        end else if (addr_hit(paddr, `OFS_CFG_CTRL) || addr_hit(paddr, `OFS_RATE_SEL)) begin
            rd_byte = {6'h00, rate_reg};
        end else if (addr_hit(paddr, `OFS_DIG_IN)) begin
            rd_byte = dig_in_byte;
        end else if (addr_hit(paddr, `OFS_STATUS_A)) begin
            rd_byte = status_a_byte;
        end else if (addr_hit(paddr, `OFS_MODE_CTRL)) begin
            rd_byte = mode_ctrl_reg;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata_reg <= `RST_WORD;
        end else if (rd_setup) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            digital_output_reg   <= `RST_BYTE;
            function_enable_reg  <= `RST_BYTE;
            function_control_reg <= `RST_BYTE;
            mode_ctrl_reg        <= `RST_BYTE;
            dor_written_reg      <= 1'b0;
        end else if (wr_en) begin
            if (addr_hit(paddr, `OFS_DIG_OUT)) begin
                digital_output_reg <= pwdata[7:0];
                dor_written_reg    <= 1'b1; // [R17]
            end
            if (addr_hit(paddr, `OFS_FUNC_EN)) begin
                function_enable_reg <= pwdata[7:0];
            end
            if (addr_hit(paddr, `OFS_FUNC_CTRL)) begin
                function_control_reg <= pwdata[7:0];
            end
            if (addr_hit(paddr, `OFS_MODE_CTRL)) begin
                mode_ctrl_reg <= pwdata[7:0];
            end
        end
    end

    // one shared rate: the later write of either register wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rate_reg <= `RST_RATE;
        end else if (wr_en && (addr_hit(paddr, `OFS_CFG_CTRL) || addr_hit(paddr, `OFS_RATE_SEL))) begin
            rate_reg <= pwdata[`RATE_MSB:`RATE_LSB]; // [R9]
        end
    end

    assign rate_out_lo = rate_reg[0]; // [R9]
    assign rate_out_hi = rate_reg[1]; // [R9]

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_out          <= 1'b0;
            side_select      <= 1'b0;
            drive_select_a_n <= `RST_SEL_N;
            drive_select_b_n <= `RST_SEL_N;
        end else begin
            dir_out          <= dir_next; // [R1] [R2]
            side_select      <= dor_written_reg & side_req; // [R15] [R17]
            drive_select_a_n <= sel_a_n | ~dor_written_reg; // [R3] [R17]
            drive_select_b_n <= sel_b_n | ~dor_written_reg; // [R3] [R17]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ppm_pins_oe        <= 1'b0;
            ppm_dir            <= 1'b0;
            ppm_side_select    <= 1'b0;
            ppm_drive_select_n <= `RST_SEL_N;
        end else begin
            ppm_pins_oe        <= ppm_active; // [R8]
            ppm_dir            <= ppm_active & dir_next; // [R8]
            ppm_side_select    <= ppm_active & dor_written_reg & side_req; // [R8]
            ppm_drive_select_n <= ~ppm_active | sel_ppm_n | ~dor_written_reg; // [R7]
        end
    end

    // programmed accesses keep the acknowledge high, so only a low one counts
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dma_request    <= 1'b0;
            dma_transfer   <= 1'b0;
            read_gate_diag <= 1'b0;
        end else begin
            dma_request    <= fdc_dma_req & dma_enable; // [R10] [R11]
            dma_transfer   <= ~ack_n_sync & dma_enable; // [R16]
            read_gate_diag <= mode_ctrl_reg[`MODE_READ_GATE_DIAG] & door_sync; // [R14]
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_dir_inward: assert property (dir_next |=> dir_out && ppm_dir == $past(ppm_active)) // [R1]
        else $error("direction not active on inward seek");
    a_dir_outward: assert property (seek_active && !seek_inward |=> !dir_out) // [R1]
        else $error("direction active on outward seek");
    a_dir_rw: assert property (rw_active |=> !dir_out && !ppm_dir) // [R2]
        else $error("direction active during read or write");
    a_sel_decode: assert property (dor_written_reg // [R3]
        && !function_enable_reg[`FEN_FOUR_DRIVE]
        && !function_control_reg[`FCTL_SWAP] && digital_output_reg == 8'h10
        |=> !drive_select_a_n && drive_select_b_n)
        else $error("drive zero select wrong");
    a_sel_motor: assert property (!function_enable_reg[`FEN_FOUR_DRIVE] // [R4]
        && digital_output_reg[`DOUT_MOTOR_MSB:`DOUT_MOTOR_LSB] == 4'h0
        |=> drive_select_a_n && drive_select_b_n)
        else $error("select active with motor off");
    a_four_motor: assert property (function_enable_reg[`FEN_FOUR_DRIVE] // [R4]
        && digital_output_reg[`DOUT_MOTOR_MSB:`DOUT_MOTOR_LSB] == 4'h0
        |=> drive_select_a_n && drive_select_b_n)
        else $error("encoded select active with motor off");
    a_four_drive: assert property (dor_written_reg // [R5]
        && function_enable_reg[`FEN_FOUR_DRIVE]
        && !function_control_reg[`FCTL_SWAP] && digital_output_reg == 8'h83
        |=> !drive_select_a_n && !drive_select_b_n)
        else $error("four drive code wrong");
    a_swap_drive: assert property (dor_written_reg // [R6]
        && !function_enable_reg[`FEN_FOUR_DRIVE]
        && function_control_reg[`FCTL_SWAP] && digital_output_reg == 8'h10
        |=> drive_select_a_n && !drive_select_b_n)
        else $error("swap did not exchange selects");
    a_ppm_select: assert property (ppm_active && dor_written_reg // [R7]
        && !function_enable_reg[`FEN_FOUR_DRIVE] && !function_control_reg[`FCTL_SWAP]
        && digital_output_reg == 8'h21 |=> !ppm_drive_select_n)
        else $error("shared select wrong");
    a_ppm_swap: assert property (ppm_active && dor_written_reg // [R7]
        && !function_enable_reg[`FEN_FOUR_DRIVE] && function_control_reg[`FCTL_SWAP]
        && digital_output_reg == 8'h10 |=> ppm_drive_select_n)
        else $error("shared select not swapped");
    a_ppm_share: assert property (!ppm_active |=> !ppm_pins_oe && !ppm_dir // [R8]
        && !ppm_side_select && ppm_drive_select_n)
        else $error("shared pins driven outside printer-port mode");
    a_ppm_side: assert property (ppm_active && dor_written_reg && side_req // [R8]
        |=> ppm_side_select)
        else $error("shared side select missing");
    a_door_ppm: assert property (rd_setup && ppm_active && addr_hit(paddr, `OFS_DIG_IN) // [R8]
        |=> prdata[`DIN_DOOR] == $past(ppm_door_sync))
        else $error("shared door change not readable");
    a_rate_follow: assert property (wr_en && addr_hit(paddr, `OFS_RATE_SEL) // [R9]
        |=> {rate_out_hi, rate_out_lo} == $past(pwdata[`RATE_MSB:`RATE_LSB]))
        else $error("rate outputs do not follow last write");
    a_rate_cfg: assert property (wr_en && addr_hit(paddr, `OFS_CFG_CTRL) // [R9]
        |=> {rate_out_hi, rate_out_lo} == $past(pwdata[`RATE_MSB:`RATE_LSB]))
        else $error("rate outputs do not follow config write");
    a_dma_gated: assert property (!second_mode && !digital_output_reg[`DOUT_DMA_EN] // [R10]
        |=> !dma_request)
        else $error("dma request while disabled");
    a_dma_always: assert property (second_mode && fdc_dma_req |=> dma_request) // [R11]
        else $error("dma request blocked in second mode");
    a_dma_reserved: assert property (rd_setup && second_mode // [R11]
        && addr_hit(paddr, `OFS_DIG_OUT) |=> !prdata[`DOUT_DMA_EN])
        else $error("reserved dma enable bit reads set");
    a_status_drive: assert property (rd_setup && addr_hit(paddr, `OFS_STATUS_A) // [R12]
        |=> prdata[`SRA_DRIVE2] == $past(second_mode && drive2_sync))
        else $error("status a drive bit wrong");
    a_door_read: assert property (rd_setup && addr_hit(paddr, `OFS_DIG_IN) // [R13]
        |=> prdata[`DIN_DOOR] == $past(door_level))
        else $error("door change not readable");
    a_read_gate: assert property (!mode_ctrl_reg[`MODE_READ_GATE_DIAG] |=> !read_gate_diag) // [R14]
        else $error("read gate active while not selected");
    a_side_sel: assert property (dor_written_reg && side_req |=> side_select) // [R15]
        else $error("side select not active for side one");
    a_side_zero: assert property (!side_req |=> !side_select) // [R15]
        else $error("side select active for side zero");
    a_reset_idle: assert property (!dor_written_reg // [R17]
        |=> drive_select_a_n && drive_select_b_n && !dir_out && !side_select)
        else $error("outputs active before first digital output write");

    c_four_drive: cover property (function_enable_reg[`FEN_FOUR_DRIVE] ##1 !drive_select_b_n);
    c_ppm_share: cover property (ppm_pins_oe && ppm_dir);
    c_dma_second: cover property (second_mode && dma_request);
    c_swap_select: cover property (function_control_reg[`FCTL_SWAP] && !drive_select_b_n);
    c_read_gate: cover property (read_gate_diag);

endmodule

// file: design/fdd_pin_consts.svh
`ifndef FDD_PIN_CONSTS_SVH
`define FDD_PIN_CONSTS_SVH

// register byte offsets on the apb bus
`define OFS_DIG_OUT      8'h00
`define OFS_FUNC_EN      8'h04
`define OFS_FUNC_CTRL    8'h08
`define OFS_CFG_CTRL     8'h0C
`define OFS_RATE_SEL     8'h10
`define OFS_DIG_IN       8'h14
`define OFS_STATUS_A     8'h18
`define OFS_MODE_CTRL    8'h1C

// digital output register fields
`define DOUT_DRV_LSB     0
`define DOUT_DRV_MSB     1
`define DOUT_DMA_EN      3
`define DOUT_MOTOR_LSB   4
`define DOUT_MOTOR_MSB   7

// fields of the other registers: single bits and two-bit ranges
`define FEN_FOUR_DRIVE   4
`define FCTL_SWAP        4
`define RATE_LSB         0
`define RATE_MSB         1
`define DIN_DOOR         7
`define SRA_DRIVE2       6
`define MODE_COMPAT_LSB  0
`define MODE_COMPAT_MSB  1
`define MODE_PPM         2
`define MODE_EXT_CTRL    3
`define MODE_READ_GATE_DIAG       4

// reset values
`define RST_BYTE         8'h00
`define RST_RATE         2'h0
`define RST_WORD         32'h0000_0000
`define RST_SEL_N        1'b1

`endif

// file: design/fdd_pin_pkg.sv
package fdd_pin_pkg;

    typedef enum logic [1:0] {
        at_compat_mode      = 2'h0,
        model30_compat_mode = 2'h1,
        second_compat_mode  = 2'h2,
        illegal_compat_mode = 2'h3
    } compat_mode_t;

    typedef logic [1:0] drive_num_t;
    typedef logic [3:0] motor_t;
    typedef logic [1:0] rate_t;

endpackage

// file: design/sync_bits.sv
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sync_bits needs WIDTH of at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic first_reg;
            // the first stage feeds the second stage only
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    first_reg   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    first_reg   <= async_in[i];
                    sync_out[i] <= first_reg;
                end
            end
        end
    endgenerate

endmodule

// file: design/drive_select_decode.sv
`timescale 1ns/1ps
module drive_select_decode
    import fdd_pin_pkg::*;
(
    input  fdd_pin_pkg::drive_num_t drive_num,
    input  fdd_pin_pkg::motor_t     motor_on,
    input  wire logic               four_drive,
    input  wire logic               swap,
    output logic                    sel_a_n,
    output logic                    sel_b_n,
    output logic                    sel_ppm_n
);

    function automatic logic sel_hit(input drive_num_t num, input drive_num_t want);
        sel_hit = (num == want);
    endfunction

    drive_num_t eff_num;
    logic       motor_ok;

    always_comb begin
        // swap only trades the first two drives
        eff_num  = (swap && !drive_num[1]) ? {drive_num[1], ~drive_num[0]} : drive_num; // [R6]
        // gate with the motor of the logical drive
        motor_ok = motor_on[drive_num]; // [R4]
        if (four_drive) begin
            // encoded: external decoder combines these with the motor lines
            sel_a_n = ~(motor_ok & eff_num[0]); // [R5]
            sel_b_n = ~(motor_ok & eff_num[1]); // [R5]
        end else begin
            sel_a_n = ~(motor_ok & sel_hit(eff_num, 2'h0)); // [R3]
            sel_b_n = ~(motor_ok & sel_hit(eff_num, 2'h1)); // [R3]
        end
        sel_ppm_n = swap ? sel_a_n : sel_b_n; // [R7]
    end

endmodule

// file: tb/fdd_far_side.sv
`timescale 1ns/1ps
module fdd_far_side (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic dma_request,
    input  wire logic slow,
    input  wire logic door_open,
    input  wire logic drive2_fitted,
    output logic      door_change,
    output logic      ppm_door_change,
    output logic      second_drive_present,
    output logic      dma_acknowledge_n
);
    logic [2:0] wait_cnt;
    assign door_change          = door_open;
    assign ppm_door_change      = door_open;
    assign second_drive_present = drive2_fitted;
    // ack only answers a pending request; register accesses made while one is pending still see it low
    always_ff @(posedge clk) begin
        if (!reset_n || !dma_request) begin
            wait_cnt          <= 3'h0;
            dma_acknowledge_n <= 1'b1;
        end else if (wait_cnt != (slow ? 3'h4 : 3'h1)) begin
            wait_cnt <= wait_cnt + 3'h1;
        end else begin
            dma_acknowledge_n <= 1'b0;
        end
    end
endmodule

// file: tb/floppy_drive_pin_control_tb.sv
`timescale 1ns/1ps
module floppy_drive_pin_control_tb;
    logic        clk           = 1'b0;
    logic        reset_n       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [7:0]  paddr         = 8'h00;
    logic [31:0] pwdata        = 32'h0;
    logic        seek_active   = 1'b0;
    logic        seek_inward   = 1'b0;
    logic        rw_active     = 1'b0;
    logic        side_req      = 1'b0;
    logic        fdc_dma_req   = 1'b0;
    logic        slow          = 1'b0;
    logic        door_open     = 1'b0;
    logic        drive2_fitted = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, door_change, ppm_door_change;
    logic        second_drive_present, dma_acknowledge_n, dir_out, side_select;
    logic        drive_select_a_n, drive_select_b_n, rate_out_lo, rate_out_hi;
    logic        dma_request, dma_transfer, read_gate_diag, ppm_pins_oe;
    logic        ppm_dir, ppm_side_select, ppm_drive_select_n;
    logic [1:0]  sel;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          cycles     = 0;

    assign sel = {drive_select_a_n, drive_select_b_n};
    always #10 clk = ~clk;

    floppy_drive_pin_control dut_u (
        .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .seek_active, .seek_inward, .rw_active, .side_req,
        .fdc_dma_req, .door_change, .ppm_door_change, .second_drive_present,
        .dma_acknowledge_n, .dir_out, .side_select, .drive_select_a_n,
        .drive_select_b_n, .rate_out_lo, .rate_out_hi, .dma_request, .dma_transfer,
        .read_gate_diag, .ppm_pins_oe, .ppm_dir, .ppm_side_select, .ppm_drive_select_n
    );
    fdd_far_side far_u (
        .clk, .reset_n, .dma_request, .slow, .door_open, .drive2_fitted,
        .door_change, .ppm_door_change, .second_drive_present, .dma_acknowledge_n
    );

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake ends here instead of running forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        seek_active <= 1'b1;
        seek_inward <= 1'b1;
        side_req    <= 1'b1;
        cyc(3);
        chk(dir_out, 1'b0);
        chk(side_select, 1'b0);
        chk(sel, 2'h3);
        rd(8'h00, 32'h0);
        apb(1'b1, 8'h20, 32'hFF, r, e);
        chk(e, 1'b1);
        rd(8'h20, 32'h0);
        seek_active <= 1'b0;
        side_req    <= 1'b0;
    endtask

    task automatic t_select;
        for (int d = 0; d < 4; d++) begin
            wr(8'h00, 32'hF0 | 32'(d));
            cyc(2);
            chk(sel, {d != 0, d != 1});
        end
        wr(8'h00, 32'h11);
        cyc(2);
        chk(sel, 2'h3);
        wr(8'h00, 32'h21);
        cyc(2);
        chk(sel, 2'h2);
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h10);
        cyc(2);
        chk(sel, 2'h2);
        wr(8'h08, 32'h00);
        wr(8'h04, 32'h10);
        for (int d = 0; d < 4; d++) begin
            wr(8'h00, 32'hF0 | 32'(d));
            cyc(2);
            chk(sel, {d[0] == 0, d[1] == 0});
        end
        wr(8'h00, 32'h83);
        cyc(2);
        chk(sel, 2'h0);
        wr(8'h04, 32'h00);
    endtask

    task automatic t_head;
        wr(8'h00, 32'h10);
        seek_active <= 1'b1;
        seek_inward <= 1'b1;
        side_req    <= 1'b1;
        cyc(2);
        chk(dir_out, 1'b1);
        chk(side_select, 1'b1);
        seek_inward <= 1'b0;
        side_req    <= 1'b0;
        cyc(2);
        chk(dir_out, 1'b0);
        chk(side_select, 1'b0);
        seek_inward <= 1'b1;
        rw_active   <= 1'b1;
        cyc(2);
        chk(dir_out, 1'b0);
        rw_active <= 1'b0;
    endtask

    task automatic t_rate;
        wr(8'h0C, 32'h1);
        cyc(1);
        chk({rate_out_hi, rate_out_lo}, 2'h1);
        wr(8'h10, 32'h2);
        cyc(1);
        chk({rate_out_hi, rate_out_lo}, 2'h2);
        wr(8'h0C, 32'h3);
        rd(8'h10, 32'h3);
    endtask

    task automatic t_dma;
        fdc_dma_req <= 1'b1;
        wr(8'h00, 32'h0);
        cyc(2);
        chk(dma_request, 1'b0);
        wr(8'h00, 32'h8);
        cyc(2);
        chk(dma_request, 1'b1);
        cyc(8);
        chk(dma_transfer, 1'b1);
        wr(8'h1C, 32'h1);
        wr(8'h00, 32'h0);
        cyc(2);
        chk(dma_request, 1'b0);
        slow <= 1'b1;
        wr(8'h1C, 32'h2);
        cyc(2);
        chk(dma_request, 1'b1);
        cyc(12);
        chk(dma_transfer, 1'b1);
        wr(8'h00, 32'h8);
        rd(8'h00, 32'h0);
        fdc_dma_req <= 1'b0;
        wr(8'h1C, 32'h0);
    endtask

    task automatic t_status;
        door_open     <= 1'b1;
        drive2_fitted <= 1'b1;
        wr(8'h1C, 32'h2);
        cyc(5);
        rd(8'h18, 32'h40);
        rd(8'h14, 32'h80);
        wr(8'h1C, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h1C, 32'h10);
        cyc(3);
        chk(read_gate_diag, 1'b1);
        door_open <= 1'b0;
        cyc(5);
        chk(read_gate_diag, 1'b0);
        rd(8'h14, 32'h0);
        wr(8'h1C, 32'h0);
    endtask

    task automatic t_ppm;
        wr(8'h1C, 32'h4);
        wr(8'h00, 32'h21);
        seek_active <= 1'b1;
        side_req    <= 1'b1;
        door_open   <= 1'b1;
        cyc(5);
        chk(ppm_pins_oe, 1'b1);
        chk({ppm_dir, ppm_side_select}, 2'h3);
        chk(ppm_drive_select_n, 1'b0);
        rd(8'h14, 32'h80);
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h10);
        cyc(2);
        chk(ppm_drive_select_n, 1'b1);
        wr(8'h1C, 32'hC);
        cyc(2);
        chk({ppm_pins_oe, ppm_dir, ppm_drive_select_n}, 3'h1);
        wr(8'h08, 32'h0);
        wr(8'h1C, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_select;
        t_head;
        t_rate;
        t_dma;
        t_status;
        t_ppm;
        close_out;
    end
endmodule
